// ==== hdl/fpd_pkg.sv ====
package fpd_pkg;

  // ----------------------------------------------------------------
  // opcodes and mode bits
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_PWR_DOWN = 8'hb9;
  localparam logic [7:0] OP_RELEASE_ID = 8'hab;
  localparam logic [7:0] OP_MFR_DEV = 8'h90;
  localparam logic [7:0] OP_MFR_DEV_DUAL = 8'h92;
  localparam logic [7:0] OP_MFR_DEV_QUAD = 8'h94;
  localparam logic [7:0] OP_UNIQUE_ID = 8'h4b;
  localparam logic [7:0] OP_STD_ID = 8'h9f;
  localparam logic [7:0] OP_READ_STATUS = 8'h05;
  localparam logic [7:0] MODE_BITS = 8'hf0; // continuation bits, Fx form

  // ----------------------------------------------------------------
  // identification values (all arbitrary)
  // ----------------------------------------------------------------
  localparam logic [7:0] MFR_ID = 8'h5a; // arbitrary
  localparam logic [7:0] DEV_ID = 8'h16; // arbitrary
  localparam logic [7:0] MEM_TYPE = 8'h40; // arbitrary
  localparam logic [7:0] CAPACITY = 8'h17; // arbitrary
  localparam logic [63:0] UNIQUE_ID = 64'h0123_4567_89ab_cdef; // arbitrary
  localparam int BUSY_BIT = 0; // busy flag position in status byte

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int PD_ENTRY_NS = 3000;
  localparam int REL_PLAIN_NS = 3000;
  localparam int REL_ID_NS = 3000;
  localparam int TMR_W = 12;
  localparam logic [TMR_W-1:0] ENTRY_CYC = TMR_W'(PD_ENTRY_NS / CLK_PERIOD_NS);
  localparam logic [TMR_W-1:0] REL_PLAIN_CYC =
    TMR_W'((REL_PLAIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TMR_W-1:0] REL_ID_CYC =
    TMR_W'((REL_ID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TMR_W-1:0] CS_GAP_CYC = 12'h004;
  localparam logic [1:0] SCK_HALF_CYC = 2'h2;

  // ----------------------------------------------------------------
  // state types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DS_OPC = 2'b00, DS_PRE = 2'b01, DS_OUT = 2'b10, DS_SKIP = 2'b11
  } fpd_dstate_t;
  typedef enum logic [1:0] {
    PS_NORMAL = 2'b00, PS_ENTER = 2'b01, PS_DOWN = 2'b10, PS_RELEASE = 2'b11
  } fpd_pstate_t;
  typedef enum logic [1:0] {
    HS_IDLE = 2'b00, HS_FRAME = 2'b01, HS_END = 2'b10, HS_GAP = 2'b11
  } fpd_hstate_t;

  // ----------------------------------------------------------------
  // command decoding shared by both ends
  // ----------------------------------------------------------------
  // clocks between opcode and first output bit
  function automatic logic [5:0] preClocks(input logic [7:0] op);
    case (op)
      OP_RELEASE_ID, OP_MFR_DEV: preClocks = 6'h18;
      OP_MFR_DEV_DUAL: preClocks = 6'h10;
      OP_MFR_DEV_QUAD: preClocks = 6'h0c;
      OP_UNIQUE_ID: preClocks = 6'h20;
      default: preClocks = 6'h00;
    endcase
  endfunction : preClocks

  // bits per clock after the opcode
  function automatic logic [2:0] laneWidth(input logic [7:0] op);
    case (op)
      OP_MFR_DEV_DUAL: laneWidth = 3'h2;
      OP_MFR_DEV_QUAD: laneWidth = 3'h4;
      default: laneWidth = 3'h1;
    endcase
  endfunction : laneWidth

  // lines used at a lane width when the device answers
  function automatic logic [3:0] laneMask(input logic [2:0] w);
    case (w)
      3'h4: laneMask = 4'hf;
      3'h2: laneMask = 4'h3;
      default: laneMask = 4'h2;
    endcase
  endfunction : laneMask

endpackage : fpd_pkg

// ==== hdl/fpd_link_if.sv ====
`timescale 1ns/10ps
interface fpd_link_if;
  logic csN;
  logic sclk;
  logic [3:0] hostIo;
  logic [3:0] hostOe;
  logic [3:0] devIo;
  logic [3:0] devOe;
  logic [3:0] io;

  // resolved line level, undriven lines pulled high
  assign io = (hostOe & hostIo) | (devOe & devIo) | ~(hostOe | devOe);

  modport host (output csN, output sclk, output hostIo, output hostOe, input io);
  modport dev (input csN, input sclk, input io, output devIo, output devOe);
endinterface : fpd_link_if

// ==== hdl/fpd_flash_end.sv ====
`timescale 1ns/10ps
module fpd_flash_end (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // serial link
  fpd_link_if.dev link,
  // device core side
  input wire logic busyIn,
  output logic pwrDown,
  output logic cmdReady
);

  // ----------------------------------------------------------------
  // answer bytes
  // ----------------------------------------------------------------
  function automatic logic [7:0] idByte(input logic [7:0] op, input logic [3:0] idx,
                                        input logic busy);
    logic [7:0] st;
    st = 8'h00;
    st[fpd_pkg::BUSY_BIT] = busy;
    case (op)
      fpd_pkg::OP_RELEASE_ID: idByte = fpd_pkg::DEV_ID;
      fpd_pkg::OP_MFR_DEV, fpd_pkg::OP_MFR_DEV_DUAL, fpd_pkg::OP_MFR_DEV_QUAD:
        idByte = idx[0] ? fpd_pkg::DEV_ID : fpd_pkg::MFR_ID;
      fpd_pkg::OP_STD_ID: begin
        case (idx[1:0])
          2'h0: idByte = fpd_pkg::MFR_ID;
          2'h1: idByte = fpd_pkg::MEM_TYPE;
          default: idByte = fpd_pkg::CAPACITY;
        endcase
      end
      fpd_pkg::OP_UNIQUE_ID: idByte = fpd_pkg::UNIQUE_ID[8'(63 - 8 * idx) -: 8];
      fpd_pkg::OP_READ_STATUS: idByte = st;
      default: idByte = 8'hff;
    endcase
  endfunction : idByte

  // last byte index before the answer wraps
  function automatic logic [3:0] lastIdx(input logic [7:0] op);
    case (op)
      fpd_pkg::OP_MFR_DEV, fpd_pkg::OP_MFR_DEV_DUAL, fpd_pkg::OP_MFR_DEV_QUAD: lastIdx = 4'h1;
      fpd_pkg::OP_STD_ID: lastIdx = 4'h2;
      fpd_pkg::OP_UNIQUE_ID: lastIdx = 4'h7;
      default: lastIdx = 4'h0;
    endcase
  endfunction : lastIdx

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  fpd_pkg::fpd_dstate_t st_r, st_nxt;
  fpd_pkg::fpd_pstate_t pd_r, pd_nxt;
  logic csPrev_r, csPrev_nxt;
  logic sclkPrev_r, sclkPrev_nxt;
  logic [7:0] opc_r, opc_nxt;
  logic [5:0] cnt_r, cnt_nxt;
  logic extra_r, extra_nxt;
  logic [2:0] w_r, w_nxt;
  logic [3:0] idx_r, idx_nxt;
  logic [2:0] bit_r, bit_nxt;
  logic [3:0] dout_r, dout_nxt;
  logic [3:0] oe_r, oe_nxt;
  logic [fpd_pkg::TMR_W-1:0] tmr_r, tmr_nxt;

  // edge detection on the synchronous link inputs
  logic sclkRise, sclkFall, csRise, opcDone, accept;
  logic [7:0] opcNew, curByte, sh;
  logic [3:0] bitSum;
  assign sclkRise = link.sclk & ~sclkPrev_r & ~link.csN;
  assign sclkFall = ~link.sclk & sclkPrev_r & ~link.csN;
  assign csRise = link.csN & ~csPrev_r;
  assign opcDone = st_r != fpd_pkg::DS_OPC;
  assign opcNew = {opc_r[6:0], link.io[0]};
  assign curByte = idByte(opc_r, idx_r, busyIn);
  assign sh = curByte << bit_r;
  assign bitSum = {1'b0, bit_r} + {1'b0, w_r};

  // which commands the device recognises in its current state
  always_comb begin
    case (pd_r)
      fpd_pkg::PS_NORMAL: begin
        case (opcNew)
          fpd_pkg::OP_RELEASE_ID: accept = ~busyIn;
          fpd_pkg::OP_PWR_DOWN, fpd_pkg::OP_MFR_DEV, fpd_pkg::OP_MFR_DEV_DUAL,
          fpd_pkg::OP_MFR_DEV_QUAD, fpd_pkg::OP_UNIQUE_ID, fpd_pkg::OP_STD_ID,
          fpd_pkg::OP_READ_STATUS: accept = 1'b1;
          default: accept = 1'b0;
        endcase
      end
      fpd_pkg::PS_DOWN: accept = opcNew == fpd_pkg::OP_RELEASE_ID;
      default: accept = 1'b0; // entry and release delays ignore frames
    endcase
  end

  // ----------------------------------------------------------------
  // frame decoder and shifter
  // ----------------------------------------------------------------
  // next values of the frame logic
  always_comb begin
    st_nxt = st_r;
    opc_nxt = opc_r;
    cnt_nxt = cnt_r;
    extra_nxt = extra_r;
    w_nxt = w_r;
    idx_nxt = idx_r;
    bit_nxt = bit_r;
    dout_nxt = dout_r;
    oe_nxt = oe_r;
    csPrev_nxt = link.csN;
    sclkPrev_nxt = link.sclk;
    if (link.csN) begin
      st_nxt = fpd_pkg::DS_OPC; // frame ends when cs rises
      cnt_nxt = 6'h00;
      extra_nxt = 1'b0;
      oe_nxt = 4'h0;
    end else if (sclkRise) begin
      if (opcDone) begin
        extra_nxt = 1'b1; // clocks past the opcode
      end
      unique case (st_r)
        fpd_pkg::DS_OPC: begin
          opc_nxt = opcNew;
          cnt_nxt = cnt_r + 6'h01;
          if (cnt_r == 6'h07) begin
            cnt_nxt = 6'h00;
            w_nxt = fpd_pkg::laneWidth(opcNew);
            idx_nxt = 4'h0;
            bit_nxt = 3'h0;
            if (!accept || opcNew == fpd_pkg::OP_PWR_DOWN) begin
              st_nxt = fpd_pkg::DS_SKIP;
            end else if (fpd_pkg::preClocks(opcNew) == 6'h00) begin
              st_nxt = fpd_pkg::DS_OUT;
            end else begin
              st_nxt = fpd_pkg::DS_PRE;
            end
          end
        end
        fpd_pkg::DS_PRE: begin
          cnt_nxt = cnt_r + 6'h01; // address and dummy clocks
          if (cnt_nxt == fpd_pkg::preClocks(opc_r)) begin
            st_nxt = fpd_pkg::DS_OUT;
          end
        end
        fpd_pkg::DS_OUT, fpd_pkg::DS_SKIP: begin
        end
      endcase
    end else if (sclkFall && st_r == fpd_pkg::DS_OUT) begin
      unique case (w_r) // MSB first on the falling edge
        3'h4: dout_nxt = sh[7:4];
        3'h2: dout_nxt = {2'b00, sh[7:6]};
        default: dout_nxt = {2'b00, sh[7], 1'b0};
      endcase
      oe_nxt = fpd_pkg::laneMask(w_r);
      bit_nxt = bitSum[2:0];
      if (bitSum[3]) begin
        idx_nxt = (idx_r == lastIdx(opc_r)) ? 4'h0 : idx_r + 4'h1;
      end
    end
  end

  // frame registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= fpd_pkg::DS_OPC;
      opc_r <= 8'h00;
      cnt_r <= 6'h00;
      extra_r <= 1'b0;
      w_r <= 3'h1;
      idx_r <= 4'h0;
      bit_r <= 3'h0;
      dout_r <= 4'h0;
      oe_r <= 4'h0;
      csPrev_r <= 1'b1;
      sclkPrev_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      opc_r <= opc_nxt;
      cnt_r <= cnt_nxt;
      extra_r <= extra_nxt;
      w_r <= w_nxt;
      idx_r <= idx_nxt;
      bit_r <= bit_nxt;
      dout_r <= dout_nxt;
      oe_r <= oe_nxt;
      csPrev_r <= csPrev_nxt;
      sclkPrev_r <= sclkPrev_nxt;
    end
  end

  // ----------------------------------------------------------------
  // power-down sequencer
  // ----------------------------------------------------------------
  // next power state, acted on at the end of a frame
  always_comb begin
    pd_nxt = pd_r;
    tmr_nxt = tmr_r;
    unique case (pd_r)
      fpd_pkg::PS_NORMAL: begin
        if (csRise && opcDone && opc_r == fpd_pkg::OP_PWR_DOWN && !extra_r) begin
          pd_nxt = fpd_pkg::PS_ENTER;
          tmr_nxt = fpd_pkg::ENTRY_CYC - 12'h002; // cs rise is seen one cycle late
        end
      end
      fpd_pkg::PS_ENTER: begin
        tmr_nxt = tmr_r - 12'h001;
        if (tmr_r == 12'h000) begin
          pd_nxt = fpd_pkg::PS_DOWN;
        end
      end
      fpd_pkg::PS_DOWN: begin
        if (csRise && opcDone && opc_r == fpd_pkg::OP_RELEASE_ID) begin
          pd_nxt = fpd_pkg::PS_RELEASE;
          tmr_nxt = extra_r ? fpd_pkg::REL_ID_CYC - 12'h001
                            : fpd_pkg::REL_PLAIN_CYC - 12'h001;
        end
      end
      fpd_pkg::PS_RELEASE: begin
        tmr_nxt = tmr_r - 12'h001;
        if (tmr_r == 12'h000) begin
          pd_nxt = fpd_pkg::PS_NORMAL;
        end
      end
    endcase
  end

  // power registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pd_r <= fpd_pkg::PS_NORMAL;
      tmr_r <= 12'h000;
    end else begin
      pd_r <= pd_nxt;
      tmr_r <= tmr_nxt;
    end
  end

  // link and core outputs
  assign link.devIo = dout_r;
  assign link.devOe = oe_r;
  assign pwrDown = pd_r == fpd_pkg::PS_DOWN;
  assign cmdReady = pd_r == fpd_pkg::PS_NORMAL;

endmodule : fpd_flash_end

// ==== hdl/fpd_host_end.sv ====
`timescale 1ns/10ps
module fpd_host_end (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // command request
  input wire logic cmdValid,
  output logic cmdReady,
  input wire logic [7:0] cmdOp,
  input wire logic [3:0] cmdLen,
  // read data
  output logic rdValid,
  input wire logic rdReady,
  output logic [7:0] rdData,
  // serial link
  fpd_link_if.host link
);

  // address, mode and dummy bits, left aligned
  function automatic logic [47:0] preBits(input logic [7:0] op);
    case (op)
      fpd_pkg::OP_MFR_DEV_DUAL: preBits = {24'h000000, fpd_pkg::MODE_BITS, 16'h0000};
      fpd_pkg::OP_MFR_DEV_QUAD: preBits = {40'h0, fpd_pkg::MODE_BITS};
      default: preBits = 48'h0; // zero address or dummy bytes
    endcase
  endfunction : preBits

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  fpd_pkg::fpd_hstate_t st_r, st_nxt;
  logic [1:0] div_r, div_nxt;
  logic csN_r, csN_nxt;
  logic sclk_r, sclk_nxt;
  logic [3:0] io_r, io_nxt;
  logic [3:0] oe_r, oe_nxt;
  logic [55:0] tx_r, tx_nxt;
  logic [7:0] op_r, op_nxt;
  logic [3:0] len_r, len_nxt;
  logic [5:0] pre_r, pre_nxt;
  logic [7:0] k_r, k_nxt;
  logic [7:0] tot_r, tot_nxt;
  logic [7:0] rx_r, rx_nxt;
  logic [2:0] rxBit_r, rxBit_nxt;
  logic [fpd_pkg::TMR_W-1:0] tmr_r, tmr_nxt;
  logic [7:0] fifo_r [2];
  logic [7:0] fifoIn;
  logic wp_r, wp_nxt, rp_r, rp_nxt;
  logic [1:0] cnt_r, cnt_nxt;
  logic tick, push, pop;
  logic [2:0] w;
  logic [3:0] rxSum;
  logic [7:0] rxShift, rdBase, nRead;

  assign w = fpd_pkg::laneWidth(op_r);
  assign tick = st_r == fpd_pkg::HS_FRAME && div_r == fpd_pkg::SCK_HALF_CYC - 2'h1
                && cnt_r != 2'h2; // a full buffer stops the serial clock
  assign rdBase = 8'h08 + {2'h0, pre_r};
  assign pop = rdValid && rdReady;
  assign rxSum = {1'b0, rxBit_r} + {1'b0, w};
  always_comb begin
    unique case (w)
      3'h4: rxShift = {rx_r[3:0], link.io};
      3'h2: rxShift = {rx_r[5:0], link.io[1:0]};
      default: rxShift = {rx_r[6:0], link.io[1]};
    endcase
  end
  assign nRead = (cmdOp == fpd_pkg::OP_MFR_DEV_QUAD) ? {3'h0, cmdLen, 1'b0} :
                 (cmdOp == fpd_pkg::OP_MFR_DEV_DUAL) ? {2'h0, cmdLen, 2'h0} :
                 {1'b0, cmdLen, 3'h0};

  // ----------------------------------------------------------------
  // frame sequencer
  // ----------------------------------------------------------------
  // next values: divider, frame, shifters
  always_comb begin
    st_nxt = st_r;
    div_nxt = 2'h0;
    csN_nxt = csN_r;
    sclk_nxt = sclk_r;
    io_nxt = io_r;
    oe_nxt = oe_r;
    tx_nxt = tx_r;
    op_nxt = op_r;
    len_nxt = len_r;
    pre_nxt = pre_r;
    k_nxt = k_r;
    tot_nxt = tot_r;
    rx_nxt = rx_r;
    rxBit_nxt = rxBit_r;
    tmr_nxt = tmr_r;
    push = 1'b0;
    fifoIn = rxShift;
    unique case (st_r)
      fpd_pkg::HS_IDLE: begin
        if (cmdValid) begin
          st_nxt = fpd_pkg::HS_FRAME;
          csN_nxt = 1'b0;
          op_nxt = cmdOp;
          len_nxt = cmdLen;
          pre_nxt = (cmdLen == 4'h0) ? 6'h00 : fpd_pkg::preClocks(cmdOp);
          tot_nxt = 8'h08 + ((cmdLen == 4'h0) ? 8'h00 : {2'h0, fpd_pkg::preClocks(cmdOp)})
                    + nRead;
          tx_nxt = {cmdOp[6:0], preBits(cmdOp), 1'b0};
          io_nxt = {3'h0, cmdOp[7]};
          oe_nxt = 4'h1;
          k_nxt = 8'h00;
          rxBit_nxt = 3'h0;
        end
      end
      fpd_pkg::HS_FRAME: begin
        div_nxt = (cnt_r == 2'h2) ? div_r : div_r + 2'h1;
        if (tick) begin
          div_nxt = 2'h0;
          sclk_nxt = ~sclk_r;
          if (!sclk_r) begin
            k_nxt = k_r + 8'h01; // rising edge, device samples
          end else begin
            if (k_r > rdBase) begin // sample just before the fall
              rx_nxt = rxShift;
              rxBit_nxt = rxSum[2:0];
              push = rxSum[3];
            end
            if (k_r == tot_r) begin
              st_nxt = fpd_pkg::HS_END;
            end else if (k_r < 8'h08) begin
              io_nxt = {3'h0, tx_r[55]};
              tx_nxt = {tx_r[54:0], 1'b0};
            end else if (k_r < rdBase) begin
              unique case (w)
                3'h4: io_nxt = tx_r[55:52];
                3'h2: io_nxt = {2'h0, tx_r[55:54]};
                default: io_nxt = {3'h0, tx_r[55]};
              endcase
              tx_nxt = tx_r << w;
              oe_nxt = (w == 3'h1) ? 4'h1 : fpd_pkg::laneMask(w);
            end else begin
              oe_nxt = 4'h0; // hand lines to the device
            end
          end
        end
      end
      fpd_pkg::HS_END: begin
        csN_nxt = 1'b1; // cs rises right after the last clock
        oe_nxt = 4'h0;
        st_nxt = fpd_pkg::HS_GAP;
        if (op_r == fpd_pkg::OP_PWR_DOWN) begin
          tmr_nxt = fpd_pkg::CS_GAP_CYC + fpd_pkg::ENTRY_CYC;
        end else if (op_r == fpd_pkg::OP_RELEASE_ID) begin
          tmr_nxt = fpd_pkg::CS_GAP_CYC + ((len_r == 4'h0) ? fpd_pkg::REL_PLAIN_CYC
                                                         : fpd_pkg::REL_ID_CYC);
        end else begin
          tmr_nxt = fpd_pkg::CS_GAP_CYC;
        end
      end
      fpd_pkg::HS_GAP: begin
        tmr_nxt = tmr_r - 12'h001; // cs held high
        if (tmr_r == 12'h000) begin
          st_nxt = fpd_pkg::HS_IDLE;
        end
      end
    endcase
  end

  // frame registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= fpd_pkg::HS_IDLE;
      div_r <= 2'h0;
      csN_r <= 1'b1;
      sclk_r <= 1'b0;
      io_r <= 4'h0;
      oe_r <= 4'h0;
      tx_r <= 56'h0;
      op_r <= 8'h00;
      len_r <= 4'h0;
      pre_r <= 6'h00;
      k_r <= 8'h00;
      tot_r <= 8'h00;
      rx_r <= 8'h00;
      rxBit_r <= 3'h0;
      tmr_r <= 12'h000;
    end else begin
      st_r <= st_nxt;
      div_r <= div_nxt;
      csN_r <= csN_nxt;
      sclk_r <= sclk_nxt;
      io_r <= io_nxt;
      oe_r <= oe_nxt;
      tx_r <= tx_nxt;
      op_r <= op_nxt;
      len_r <= len_nxt;
      pre_r <= pre_nxt;
      k_r <= k_nxt;
      tot_r <= tot_nxt;
      rx_r <= rx_nxt;
      rxBit_r <= rxBit_nxt;
      tmr_r <= tmr_nxt;
    end
  end

  // ----------------------------------------------------------------
  // two-entry read buffer
  // ----------------------------------------------------------------
  // pointer and fill count
  always_comb begin
    wp_nxt = push ? ~wp_r : wp_r;
    rp_nxt = pop ? ~rp_r : rp_r;
    cnt_nxt = cnt_r + {1'b0, push} - {1'b0, pop};
  end

  // buffer registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_r <= 1'b0;
      rp_r <= 1'b0;
      cnt_r <= 2'h0;
      fifo_r[0] <= 8'h00;
      fifo_r[1] <= 8'h00;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
      if (push) begin
        fifo_r[wp_r] <= fifoIn;
      end
    end
  end

  // outputs
  assign rdValid = cnt_r != 2'h0;
  assign rdData = fifo_r[rp_r];
  assign cmdReady = st_r == fpd_pkg::HS_IDLE;
  assign link.csN = csN_r;
  assign link.sclk = sclk_r;
  assign link.hostIo = io_r;
  assign link.hostOe = oe_r;

endmodule : fpd_host_end

// ==== verification/fpd_link_assertions.sv ====
`timescale 1ns/10ps
module fpd_link_assertions (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // link lines
  input wire logic csN,
  input wire logic sclk,
  input wire logic [3:0] hostIo,
  input wire logic [3:0] hostOe,
  input wire logic [3:0] devIo,
  input wire logic [3:0] devOe,
  input wire logic [3:0] io
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------------
  // link checks
  // ----------------------------------------------------------------
  a_no_line_fight: assert property ((hostOe & devOe) == 4'h0)
    else $error("host and device drive a line together");
  a_dev_quiet_idle: assert property (csN ##1 csN ##1 csN |-> devOe == 4'h0)
    else $error("device drives a line while deselected");
  a_dev_lane_set: assert property (|devOe |-> devOe inside {4'h2, 4'h3, 4'hf})
    else $error("device drives an illegal lane set");
  a_oe_after_fall: assert property ($rose(|devOe) |-> !$past(sclk) && ($past(sclk, 2) || $past(sclk, 3)))
    else $error("device output starts off a falling clock");
  a_bit_on_fall: assert property (|devOe && $past(|devOe) && $changed(devIo) |-> !$past(sclk) && ($past(sclk, 2) || $past(sclk, 3)))
    else $error("device data changes off a falling clock");
  a_sclk_idle_low: assert property (csN |-> !sclk)
    else $error("serial clock high while deselected");
  a_sclk_half_period: assert property ($changed(sclk) |=> $stable(sclk))
    else $error("serial clock half period too short");
  a_host_rise_stable: assert property ($rose(sclk) |-> $stable(hostIo))
    else $error("host data changes at a rising clock");
  a_line_rise_stable: assert property ($rose(sclk) |-> $stable(io))
    else $error("resolved line changes at a rising clock");
  a_cs_gap_min: assert property ($rose(csN) |-> csN [*5])
    else $error("chip select gap too short");
endmodule : fpd_link_assertions

// ==== verification/flash_powerdown_id_cmds_bench.sv ====
`timescale 1ns/10ps
module flash_powerdown_id_cmds_bench;
  // ----------------------------------------------------------------
  // stimulus, ends and checker
  // ----------------------------------------------------------------
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cmdValid = 1'b0;
  logic rdReady = 1'b0;
  logic busyIn = 1'b0;
  logic [7:0] cmdOp = 8'h00;
  logic [3:0] cmdLen = 4'h0;
  logic hReady, rdValid, pwrDown, dReady;
  logic [7:0] rdData;
  logic [31:0] seed = 32'hc5a9ad16;
  logic [7:0] ops [6] = '{fpd_pkg::OP_RELEASE_ID, fpd_pkg::OP_MFR_DEV, fpd_pkg::OP_MFR_DEV_DUAL,
    fpd_pkg::OP_MFR_DEV_QUAD, fpd_pkg::OP_UNIQUE_ID, fpd_pkg::OP_STD_ID};
  int err_count = 0;
  int n_tests = 0;

  // 250 MHz clock
  always #2 clk = ~clk;

  fpd_link_if link ();
  fpd_host_end fpd_host_end_i (.clk(clk), .rst_n(rst_n), .cmdValid(cmdValid),
    .cmdReady(hReady), .cmdOp(cmdOp), .cmdLen(cmdLen), .rdValid(rdValid), .rdReady(rdReady),
    .rdData(rdData), .link(link.host));
  fpd_flash_end fpd_flash_end_i (.clk(clk), .rst_n(rst_n), .link(link.dev), .busyIn(busyIn),
    .pwrDown(pwrDown), .cmdReady(dReady));
  fpd_link_assertions fpd_link_assertions_i (.clk(clk), .rst_n(rst_n), .csN(link.csN),
    .sclk(link.sclk), .hostIo(link.hostIo), .hostOe(link.hostOe), .devIo(link.devIo),
    .devOe(link.devOe), .io(link.io));

  // next random word
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // expected byte i of a read
  function automatic logic [7:0] expByte(input logic [7:0] op, input int i);
    logic [23:0] std;
    std = {fpd_pkg::MFR_ID, fpd_pkg::MEM_TYPE, fpd_pkg::CAPACITY};
    case (op)
      fpd_pkg::OP_RELEASE_ID: expByte = fpd_pkg::DEV_ID;
      fpd_pkg::OP_STD_ID: expByte = std[23 - 8 * (i % 3) -: 8];
      fpd_pkg::OP_UNIQUE_ID: expByte = fpd_pkg::UNIQUE_ID[63 - 8 * (i % 8) -: 8];
      fpd_pkg::OP_READ_STATUS: expByte = {7'h00, busyIn};
      default: expByte = (i % 2) ? fpd_pkg::DEV_ID : fpd_pkg::MFR_ID;
    endcase
  endfunction : expByte

  // compare and count
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // one frame; quiet means undriven lines, read as all ones
  task automatic runCmd(input logic [7:0] op, input logic [3:0] len, input logic quiet);
    int n;
    int k;
    n = 0;
    k = 0;
    @(negedge clk);
    cmdOp = op;
    cmdLen = len;
    cmdValid = 1'b1;
    @(negedge clk);
    cmdValid = 1'b0;
    while (n < len && k < 20000) begin
      @(negedge clk);
      seed = lfsr(seed);
      rdReady = seed[0] | seed[1]; // random reader stalls
      if (rdValid && rdReady) begin
        check(rdData, quiet ? 8'hff : expByte(op, n));
        n++;
      end
      k++;
    end
    if (n < len) begin
      err_count++;
      $display("unexpected at %0t: read count %h expected %h", $time, n, len);
    end
    @(negedge clk);
    rdReady = 1'b0;
    k = 0;
    while (!hReady && k < 20000) begin
      @(negedge clk);
      k++;
    end
    if (!hReady) begin
      err_count++;
      $display("unexpected at %0t: ready %h expected %h", $time, hReady, 1'b1);
    end
  endtask : runCmd

  // verdict and end of run
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_of_test

  // main sequence
  initial begin
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    check({6'h00, pwrDown, dReady}, 8'h01);
    for (int i = 0; i < 18; i++) begin
      seed = lfsr(seed);
      runCmd(ops[i % 6], (i < 6) ? 4'hf : 4'(seed[3:0] % 15 + 1), 1'b0);
    end
    $display("test id reads done");
    busyIn = 1'b1;
    runCmd(fpd_pkg::OP_RELEASE_ID, 4'h2, 1'b1);
    runCmd(fpd_pkg::OP_READ_STATUS, 4'h2, 1'b0);
    busyIn = 1'b0;
    runCmd(fpd_pkg::OP_READ_STATUS, 4'h1, 1'b0);
    runCmd(fpd_pkg::OP_PWR_DOWN, 4'h1, 1'b1);
    check({7'h00, pwrDown}, 8'h00);
    $display("test busy and long power-down frame done");
    for (int j = 0; j < 2; j++) begin
      runCmd(fpd_pkg::OP_PWR_DOWN, 4'h0, 1'b0);
      check({7'h00, pwrDown}, 8'h01);
      runCmd(fpd_pkg::OP_STD_ID, 4'h3, 1'b1);
      runCmd(fpd_pkg::OP_READ_STATUS, 4'h1, 1'b1);
      runCmd(fpd_pkg::OP_RELEASE_ID, 4'(j * 2), 1'b0);
      check({6'h00, pwrDown, dReady}, 8'h01);
      runCmd(fpd_pkg::OP_STD_ID, 4'h3, 1'b0);
    end
    $display("test power-down and release done");
    end_of_test();
  end

  // watchdog, far beyond the expected run of about 15000 cycles
  initial begin
    #(4 * 60000);
    err_count++;
    end_of_test();
  end
endmodule : flash_powerdown_id_cmds_bench
